// ==== rtl/osd_detector.v ====
// Original size detector: captures five reflective sensor levels on a
// trigger, decodes document size and holds result for the control side.
// Assumes all inputs synchronous to clk_i and settings static during use.
`timescale 1ns/10ps
`default_nettype none
`include "osd_defs.vh"

module osd_detector (
  input wire clk_i,
  input wire rst_n_i,
  input wire width_point_one_i,
  input wire width_point_two_i,
  input wire width_point_three_i,
  input wire length_point_one_i,
  input wire length_point_two_i,
  input wire cover_start_detect_sensor_i,
  input wire cover_position_sensor_i,
  input wire start_key_i,
  input wire heavy_black_i,
  input wire region_i,
  input wire smallest_size_enable_i,
  input wire [1:0] long_size_choice_i,
  output reg [4:0] auto_size_sensors_o,
  output reg [7:0] size_code_readout_o,
  output reg [4:0] size_o,
  output reg fallback_o,
  output reg done_o
);

  reg start_det_q;
  reg start_key_q;
  reg [4:0] pat_q;
  reg [4:0] pat_d;
  reg fb_q;
  reg fb_d;
  reg eval_q;
  wire start_edge;
  wire key_edge;
  wire capture;
  wire [4:0] raw_pat;
  wire [4:0] dec_size;

  // Raw sensor pattern, high means point covered
  assign raw_pat = {length_point_two_i, length_point_one_i, width_point_one_i,
                    width_point_two_i, width_point_three_i};

  // Trigger edges; start-detect counts only with cover closing
  assign start_edge = cover_start_detect_sensor_i & ~start_det_q;
  assign key_edge = start_key_i & ~start_key_q;
  assign capture = (~cover_position_sensor_i & start_edge) |
                   (cover_position_sensor_i & key_edge);

  // Fallback: outer width point dropped, inner point decides width
  always @* begin
    pat_d = raw_pat;
    fb_d = 1'b0;
    if (heavy_black_i) begin
      pat_d[`OSD_BIT_W3] = raw_pat[`OSD_BIT_W1];
      fb_d = 1'b1;
    end
  end

  // Size lookup on the held pattern
  osd_decode u_decode (
    .pattern_i(pat_q),
    .region_i(region_i),
    .smallest_size_enable_i(smallest_size_enable_i),
    .long_size_choice_i(long_size_choice_i),
    .size_o(dec_size)
  );

  // Edge history and continuous sensor forwarding
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_det_q <= 1'b0;
      start_key_q <= 1'b0;
      auto_size_sensors_o <= `OSD_PAT_NONE;
    end else begin
      start_det_q <= cover_start_detect_sensor_i;
      start_key_q <= start_key_i;
      auto_size_sensors_o <= raw_pat;
    end
  end

  // Capture stage then result stage; results hold between captures, done pulses once
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pat_q <= `OSD_PAT_NONE;
      fb_q <= 1'b0;
      eval_q <= 1'b0;
      size_code_readout_o <= `OSD_CODE_ZERO;
      size_o <= `OSD_SZ_NONE;
      fallback_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      eval_q <= capture;
      done_o <= eval_q;
      if (capture) begin
        pat_q <= pat_d;
        fb_q <= fb_d;
      end
      if (eval_q) begin
        size_code_readout_o <= {3'b000, pat_q};
        size_o <= dec_size;
        fallback_o <= fb_q;
      end
    end
  end

endmodule // osd_detector
`default_nettype wire

// ==== rtl/osd_defs.vh ====
// Constants for the original size detector: code layout, size codes, settings.
// Assumes inclusion by bare name from the detector design files.
`ifndef OSD_DEFS_VH
`define OSD_DEFS_VH

// Code bit positions
`define OSD_BIT_W1 2
`define OSD_BIT_W2 1
`define OSD_BIT_W3 0
`define OSD_BIT_L1 3
`define OSD_BIT_L2 4
`define OSD_PAT_W 5
`define OSD_CODE_ZERO 8'h00

// Sensor patterns (five-bit, matching code bits 4..0)
`define OSD_PAT_NONE 5'h00
`define OSD_PAT_ALL 5'h1f
`define OSD_PAT_W12_L12 5'h1e
`define OSD_PAT_W1_L12 5'h1c
`define OSD_PAT_W1_L1 5'h0c
`define OSD_PAT_W123 5'h07
`define OSD_PAT_L1 5'h08
`define OSD_PAT_W12 5'h06
`define OSD_PAT_L2 5'h10

// Size identifiers
`define OSD_SZ_NONE 5'h00
`define OSD_SZ_DLT_SEF 5'h01
`define OSD_SZ_LG_SEF 5'h02
`define OSD_SZ_LT_SEF 5'h03
`define OSD_SZ_LT_LEF 5'h04
`define OSD_SZ_HLT_SEF 5'h05
`define OSD_SZ_HLT_LEF 5'h06
`define OSD_SZ_A3_SEF 5'h07
`define OSD_SZ_B4_SEF 5'h08
`define OSD_SZ_A4_SEF 5'h09
`define OSD_SZ_A4_LEF 5'h0a
`define OSD_SZ_B5_SEF 5'h0b
`define OSD_SZ_B5_LEF 5'h0c
`define OSD_SZ_A5_SEF 5'h0d
`define OSD_SZ_FOOLSCAP 5'h0e
`define OSD_SZ_FOLIO 5'h0f
`define OSD_SZ_F_SEF 5'h10

// Long size choice settings
`define OSD_LONG_85 2'h0
`define OSD_LONG_825 2'h1
`define OSD_LONG_8 2'h2

// Region select
`define OSD_REGION_INCH 1'b0
`define OSD_REGION_METRIC 1'b1

`endif

// ==== rtl/osd_decode.v ====
// Combinational size decoder: captured pattern and settings to size id.
// Assumes a stable pattern from the capture register of the detector top.
`timescale 1ns/10ps
`default_nettype none
`include "osd_defs.vh"

module osd_decode (
  input wire [4:0] pattern_i,
  input wire region_i,
  input wire smallest_size_enable_i,
  input wire [1:0] long_size_choice_i,
  output reg [4:0] size_o
);

  // Table lookup per region; unlisted patterns report not detected
  always @* begin
    size_o = `OSD_SZ_NONE;
    if (region_i == `OSD_REGION_INCH) begin
      case (pattern_i)
        `OSD_PAT_ALL: size_o = `OSD_SZ_DLT_SEF;
        `OSD_PAT_W1_L12: size_o = `OSD_SZ_LG_SEF;
        `OSD_PAT_W1_L1: size_o = `OSD_SZ_LT_SEF;
        `OSD_PAT_W123: size_o = `OSD_SZ_LT_LEF;
        `OSD_PAT_L2: size_o = `OSD_SZ_HLT_LEF;
        `OSD_PAT_NONE: begin
          if (smallest_size_enable_i) size_o = `OSD_SZ_HLT_SEF;
        end
        default: size_o = `OSD_SZ_NONE;
      endcase
    end else begin
      case (pattern_i)
        `OSD_PAT_ALL: size_o = `OSD_SZ_A3_SEF;
        `OSD_PAT_W12_L12: size_o = `OSD_SZ_B4_SEF;
        `OSD_PAT_W1_L1: size_o = `OSD_SZ_A4_SEF;
        `OSD_PAT_W123: size_o = `OSD_SZ_A4_LEF;
        `OSD_PAT_L1: size_o = `OSD_SZ_B5_SEF;
        `OSD_PAT_W12: size_o = `OSD_SZ_B5_LEF;
        `OSD_PAT_W1_L12: begin
          // Three 13-inch-long sizes share one pattern
          if (long_size_choice_i == `OSD_LONG_825) size_o = `OSD_SZ_FOLIO;
          else if (long_size_choice_i == `OSD_LONG_8) size_o = `OSD_SZ_F_SEF;
          else size_o = `OSD_SZ_FOOLSCAP;
        end
        `OSD_PAT_NONE: begin
          if (smallest_size_enable_i) size_o = `OSD_SZ_A5_SEF;
        end
        default: size_o = `OSD_SZ_NONE;
      endcase
    end
  end

endmodule // osd_decode
`default_nettype wire

// ==== tb/osd_checker.sv ====
// Checker: result timing, held values and code layout of the size detector.
// Assumes bind into osd_detector, one clock domain on clk_i.
`timescale 1ns/10ps
`default_nettype none
module osd_checker (
  input wire logic clk_i, rst_n_i, cover_start_detect_sensor_i, cover_position_sensor_i,
  input wire logic start_key_i, heavy_black_i, region_i, smallest_size_enable_i,
  input wire logic width_point_three_i, fallback_o, done_o,
  input wire logic [4:0] auto_size_sensors_o, size_o,
  input wire logic [7:0] size_code_readout_o
);
  logic sd_q, key_q;
  logic [2:0] cap_q;
  wire cap = cover_position_sensor_i ? start_key_i & !key_q : cover_start_detect_sensor_i & !sd_q;
  // Trigger history and capture age, cleared in reset
  always_ff @(posedge clk_i) begin
    sd_q <= rst_n_i & cover_start_detect_sensor_i;
    key_q <= rst_n_i & start_key_i;
    cap_q <= rst_n_i ? {cap_q[1:0], cap} : 3'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence res_s; ##2 done_o; endsequence
  lat_a: assert property (cap |-> res_s)
    else $error("no result");
  cause_a: assert property (done_o |-> cap_q[1])
    else $error("stray result");
  hold_a: assert property (!done_o |-> $stable({size_code_readout_o, size_o, fallback_o}))
    else $error("result moved");
  code_a: assert property (done_o |->
    size_code_readout_o[7:1] == {3'h0, $past(auto_size_sensors_o[4:1], 1)})
    else $error("bad code");
  fb_a: assert property (done_o |-> fallback_o == $past(heavy_black_i, 2) &&
    size_code_readout_o[0] == (fallback_o ? $past(auto_size_sensors_o[2]) :
    $past(auto_size_sensors_o[0])))
    else $error("bad fallback");
  live_a: assert property ($past(rst_n_i) |->
    auto_size_sensors_o[0] == $past(width_point_three_i)) else $error("bad live");
  map_a: assert property (done_o && region_i && size_code_readout_o == 8'h1e |->
    size_o == 5'h08) else $error("bad size");
  none_a: assert property (done_o && (size_code_readout_o == 8'h01 ||
    size_code_readout_o == 8'h00 && !smallest_size_enable_i) |-> size_o == 5'h00)
    else $error("not none");
endmodule // osd_checker
bind osd_detector osd_checker chk (.*);
`default_nettype wire

// ==== tb/osd_reader.sv ====
// Control-side reader model: takes each stored result on its done pulse.
// Assumes the detector's results registered on clk_i.
`timescale 1ns/10ps
`default_nettype none
module osd_reader (
  input wire logic clk_i, done_i, fallback_i,
  input wire logic [4:0] size_i,
  input wire logic [7:0] code_i,
  output logic got_o,
  output logic [13:0] rec_o
);
  // Read the result while done is high; got follows one cycle later
  always @(posedge clk_i) begin
    got_o <= done_i;
    if (done_i) rec_o <= {fallback_i, code_i, size_i};
  end
endmodule // osd_reader
`default_nettype wire

// ==== tb/original_size_detector_bench.sv ====
// Bench: every pattern in both tables, random settings, trigger modes.
// Assumes the detector, reader model and bound checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module original_size_detector_bench;
  logic clk_i = 0, rst_n_i = 0, cover_start_detect_sensor_i = 0, cover_position_sensor_i = 0;
  logic start_key_i = 0, heavy_black_i = 0, region_i = 0, smallest_size_enable_i = 0;
  logic width_point_one_i = 0, width_point_two_i = 0, width_point_three_i = 0;
  logic length_point_one_i = 0, length_point_two_i = 0, fallback_o, done_o, got;
  logic [1:0] long_size_choice_i = 0;
  logic [4:0] auto_size_sensors_o, size_o;
  logic [7:0] size_code_readout_o;
  logic [13:0] rec, q[$];
  int failures = 0, check_count = 0, seed = 25;
  osd_detector DUT (.*);
  osd_reader rd (.clk_i, .done_i(done_o), .fallback_i(fallback_o), .size_i(size_o),
    .code_i(size_code_readout_o), .got_o(got), .rec_o(rec));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [4:0] ez(input logic [4:0] v);
    case (v)
      5'h1f: ez = region_i ? 5'h07 : 5'h01;
      5'h1c: ez = !region_i ? 5'h02 : long_size_choice_i == 2'h1 ? 5'h0f :
        long_size_choice_i == 2'h2 ? 5'h10 : 5'h0e;
      5'h0c: ez = region_i ? 5'h09 : 5'h03;
      5'h07: ez = region_i ? 5'h0a : 5'h04;
      5'h00: ez = !smallest_size_enable_i ? 5'h00 : region_i ? 5'h0d : 5'h05;
      5'h10: ez = region_i ? 5'h00 : 5'h06;
      5'h1e: ez = region_i ? 5'h08 : 5'h00;
      5'h08: ez = region_i ? 5'h0b : 5'h00;
      5'h06: ez = region_i ? 5'h0c : 5'h00;
      default: ez = 5'h00;
    endcase
  endfunction
  task chk(input logic [13:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR result expected %h seen %h", e, s);
    end
  endtask
  task report_and_stop;
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One trigger: md 0 closed start-detect, 1 open key, 2 and 3 ignored
  task go(input logic [4:0] v, input logic f, input logic [1:0] md);
    logic [4:0] a;
    a = f ? {v[4:1], v[2]} : v;
    @(posedge clk_i);
    {length_point_two_i, length_point_one_i, width_point_one_i, width_point_two_i,
      width_point_three_i, heavy_black_i, cover_position_sensor_i} <= {v, f, md[0]};
    if (md[0] ^ md[1])
      start_key_i <= 1'b1;
    else
      cover_start_detect_sensor_i <= 1'b1;
    if (!md[1])
      q.push_back({f, 3'h0, a, ez(a)});
    @(posedge clk_i);
    {start_key_i, cover_start_detect_sensor_i} <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask
  // Compare each result read by the control side with the oldest note
  always @(posedge clk_i)
    if (got === 1'b1)
      chk(rec, q.size() > 0 ? q.pop_front() : 14'h3fff);
  // Reset, then every pattern under each region
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      {region_i, smallest_size_enable_i, long_size_choice_i} <= {i[5], 3'($random(seed))};
      go(5'(i), 2'($random(seed)) == 2'h0, 2'($random(seed)));
    end
    repeat (2) @(posedge clk_i);
    if (q.size() > 0)
      failures++;
    report_and_stop;
  end
endmodule // original_size_detector_bench
`default_nettype wire
